// ==== src/ipc_card_config.sv ====
// Card-level plug and play configuration logic for the host bus interface.
//
// Overview of operation
// - Wake with zero: sleeping card number zero isolates, configured card sleeps.
// - Wake nonzero: matching sleeping card configures, isolating card sleeps.
// - Wake value equal to own card number returns pointer to identifier start.
// - In configuration, each resource byte read within the table returns byte then advances pointer.
// - Status bit 0 shows next resource byte available; bits 1 to 7 zero.
// - Card number accessible in configuration, and isolation once isolation finished.
// - Last isolated card stays isolating until it receives a card number.
// - Logical device index always reads zero; activation needs no prior write.
// - Activation bit 0 enables card; reset clears it; upper bits read zero.
// - Range check on: I/O reads return 0x55 if pattern bit set, else 0xaa.
// - Range check enable acts only while deactivated; bits 2 to 7 read zero.
// - I/O base held as high and low bytes, read and write in configuration.
// - Interrupt select keeps number in bits 0 to 3; upper bits reserved.
// - Interrupt type bits 0 and 1 have no effect; rest reserved.
// - Both channel registers read 0x04 in configuration, meaning no channel selected.
// - Unimplemented card registers read 0x00.
// - Control bits: reset settings, return to wait for key, zero card number.
// - Read port write sets address bits 2 to 9; bits 11:10=00, 1:0=11.
`default_nettype none

module ipc_card_config (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Protocol events from the key and isolation logic
  input wire logic key_seen,
  input wire logic iso_done,
  input wire logic iso_lost,
  // Card-level register port
  input wire logic [7:0] cfg_index,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // Resource settings
  output logic card_active,
  output logic range_check_active,
  output logic [7:0] range_pattern,
  output logic [15:0] io_base,
  output logic [3:0] irq_number,
  output logic [11:0] read_port_addr,
  output ipc_pkg::ipc_state_type card_state
);
  import ipc_pkg::*;

  ipc_state_type state_q;
  ipc_state_type state_d;
  logic [7:0] card_number_q;
  logic iso_fin_q;
  logic active_q;
  logic pattern_q;
  logic range_en_q;
  logic [7:0] base_high_q;
  logic [7:0] base_low_q;
  logic [3:0] irq_num_q;
  logic [1:0] irq_type_q;
  logic [11:0] read_port_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] rdata_d;
  logic [4:0] res_ptr;
  logic [7:0] res_byte;
  logic res_avail;
  logic in_cfg;
  logic in_iso;
  logic awake;
  logic wr_wake;
  logic wr_ctrl;
  logic ctl_reset;
  logic ctl_wait_key;
  logic ctl_clr_card;
  logic card_acc;
  logic wr_card;
  logic res_read;

  // Strobe decode helper for the wake, control, card number, read port and resource byte accesses.
  function automatic logic hit(input logic stb, input logic [7:0] idx, input logic [7:0] ofs);
    return stb && (idx == ofs);
  endfunction

  assign in_cfg = (state_q == IPC_CONFIG);
  assign in_iso = (state_q == IPC_ISOLATE);
  assign awake = (state_q != IPC_WAIT_KEY);

  assign wr_wake = hit(cfg_wr, cfg_index, IPC_OFS_WAKE) && awake;
  assign wr_ctrl = hit(cfg_wr, cfg_index, IPC_OFS_CFG_CTRL) && awake;
  assign ctl_reset = wr_ctrl && cfg_wdata[IPC_BIT_CTRL_RESET];
  assign ctl_wait_key = wr_ctrl && cfg_wdata[IPC_BIT_CTRL_WAIT_KEY];
  assign ctl_clr_card = wr_ctrl && cfg_wdata[IPC_BIT_CTRL_CLR_CARD];
  assign card_acc = in_cfg || (in_iso && iso_fin_q);
  assign wr_card = hit(cfg_wr, cfg_index, IPC_OFS_CARD_NUMBER) && card_acc;
  assign res_read = hit(cfg_rd, cfg_index, IPC_OFS_RES_BYTE) && !cfg_wr && in_cfg;
  // Pointer into identifier and resource data.
  ipc_res_reader u_res_reader (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ptr_clear(wr_wake && (cfg_wdata == card_number_q)),
    .advance(res_read),
    .ptr_q(res_ptr),
    .res_byte_q(res_byte),
    .res_avail(res_avail)
  );

  // Card state transitions driven by key, wake, isolation and control writes.
  always_comb begin
    state_d = state_q;
    case (state_q)
      IPC_WAIT_KEY: begin
        if (key_seen) begin
          state_d = IPC_SLEEP;
        end
      end
      IPC_SLEEP: begin
        if (wr_wake && cfg_wdata == 8'h00 && card_number_q == 8'h00) begin
          state_d = IPC_ISOLATE;
        end else if (wr_wake && cfg_wdata != 8'h00 && cfg_wdata == card_number_q) begin
          state_d = IPC_CONFIG;
        end
      end
      IPC_ISOLATE: begin
        if (wr_wake && cfg_wdata != 8'h00) begin
          state_d = IPC_SLEEP;
        end else if (wr_card) begin
          state_d = IPC_CONFIG;
        end else if (iso_lost && !iso_fin_q) begin
          state_d = IPC_SLEEP;
        end
      end
      IPC_CONFIG: begin
        if (wr_wake && cfg_wdata == 8'h00) begin
          state_d = IPC_SLEEP;
        end
      end
      default: begin
        state_d = IPC_WAIT_KEY;
      end
    endcase
    if (ctl_wait_key) begin
      state_d = IPC_WAIT_KEY;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= IPC_WAIT_KEY;
    end else begin
      state_q <= state_d;
    end
  end

  // Isolation finished flag, held only while isolating.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      iso_fin_q <= 1'b0;
    end else if (state_d != IPC_ISOLATE) begin
      iso_fin_q <= 1'b0;
    end else if (iso_done) begin
      iso_fin_q <= 1'b1;
    end
  end

  // Card number register; the control reset leaves it alone.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      card_number_q <= IPC_RST_BYTE;
    end else if (ctl_clr_card) begin
      card_number_q <= IPC_RST_BYTE;
    end else if (wr_card) begin
      card_number_q <= cfg_wdata;
    end
  end

  // Resource settings, written only in configuration state.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'b0;
      pattern_q <= 1'b0;
      range_en_q <= 1'b0;
      base_high_q <= IPC_RST_BYTE;
      base_low_q <= IPC_RST_BYTE;
      irq_num_q <= 4'h0;
      irq_type_q <= 2'h0;
    end else if (ctl_reset) begin
      active_q <= 1'b0;
      pattern_q <= 1'b0;
      range_en_q <= 1'b0;
      base_high_q <= IPC_RST_BYTE;
      base_low_q <= IPC_RST_BYTE;
      irq_num_q <= 4'h0;
      irq_type_q <= 2'h0;
    end else if (in_cfg && cfg_wr) begin
      if (cfg_index == IPC_OFS_ACTIVATION) begin
        active_q <= cfg_wdata[IPC_BIT_ACTIVE];
      end
      if (cfg_index == IPC_OFS_RANGE_CHECK) begin
        pattern_q <= cfg_wdata[IPC_BIT_PATTERN];
        range_en_q <= cfg_wdata[IPC_BIT_RANGE_EN];
      end
      if (cfg_index == IPC_OFS_BASE_HIGH) begin
        base_high_q <= cfg_wdata;
      end
      if (cfg_index == IPC_OFS_BASE_LOW) begin
        base_low_q <= cfg_wdata;
      end
      if (cfg_index == IPC_OFS_IRQ_NUMBER) begin
        irq_num_q <= cfg_wdata[3:0];
      end
      if (cfg_index == IPC_OFS_IRQ_TYPE) begin
        irq_type_q <= cfg_wdata[1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      read_port_q <= {IPC_PORT_HIGH_BITS, IPC_RST_BYTE, IPC_PORT_LOW_BITS};
    end else if (hit(cfg_wr, cfg_index, IPC_OFS_READ_PORT) && (in_cfg || in_iso)) begin
      read_port_q <= {IPC_PORT_HIGH_BITS, cfg_wdata, IPC_PORT_LOW_BITS};
    end
  end

  // Read multiplexer; anything not reachable in the current state reads zero.
  always_comb begin
    rdata_d = 8'h00;
    if (in_cfg) begin
      case (cfg_index)
        IPC_OFS_RES_BYTE: rdata_d = res_byte;
        IPC_OFS_RES_STATUS: rdata_d = {7'h00, res_avail};
        IPC_OFS_CARD_NUMBER: rdata_d = card_number_q;
        IPC_OFS_LDEV_INDEX: rdata_d = 8'h00;
        IPC_OFS_ACTIVATION: rdata_d = {7'h00, active_q};
        IPC_OFS_RANGE_CHECK: rdata_d = {6'h00, range_en_q, pattern_q};
        IPC_OFS_BASE_HIGH: rdata_d = base_high_q;
        IPC_OFS_BASE_LOW: rdata_d = base_low_q;
        IPC_OFS_IRQ_NUMBER: rdata_d = {4'h0, irq_num_q};
        IPC_OFS_IRQ_TYPE: rdata_d = {6'h00, irq_type_q};
        IPC_OFS_CHANNEL_0: rdata_d = IPC_CHANNEL_CASCADE;
        IPC_OFS_CHANNEL_1: rdata_d = IPC_CHANNEL_CASCADE;
        default: rdata_d = 8'h00;
      endcase
    end else if (in_iso && iso_fin_q && cfg_index == IPC_OFS_CARD_NUMBER) begin
      rdata_d = card_number_q;
    end
  end

  // Read data register, one cycle after the strobe.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_rd && !cfg_wr;
      if (cfg_rd && !cfg_wr) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      range_pattern <= IPC_PATTERN_CLR;
    end else begin
      range_pattern <= pattern_q ? IPC_PATTERN_SET : IPC_PATTERN_CLR;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign card_active = active_q;
  assign range_check_active = range_en_q && !active_q;
  assign io_base = {base_high_q, base_low_q};
  assign irq_number = irq_num_q;
  assign read_port_addr = read_port_q;
  assign card_state = state_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wake_zero;
    cfg_wr && cfg_index == IPC_OFS_WAKE && cfg_wdata == 8'h00;
  endsequence
  sequence s_wake_nonzero;
    cfg_wr && cfg_index == IPC_OFS_WAKE && cfg_wdata != 8'h00;
  endsequence
  sequence s_cfg_read(logic [7:0] ofs);
    cfg_rd && !cfg_wr && in_cfg && cfg_index == ofs;
  endsequence
  chk_wake_zero_iso: assert property (
    s_wake_zero and (state_q == IPC_SLEEP && card_number_q == 8'h00) |=> state_q == IPC_ISOLATE)
    else $error("Wake zero did not isolate the sleeping card.");
  chk_wake_zero_cfg: assert property (
    s_wake_zero and in_cfg |=> state_q == IPC_SLEEP)
    else $error("Wake zero did not put the configured card to sleep.");
  chk_wake_match_cfg: assert property (
    s_wake_nonzero and (state_q == IPC_SLEEP && cfg_wdata == card_number_q) |=> in_cfg)
    else $error("Matching wake did not configure the card.");
  chk_wake_iso_sleep: assert property (
    s_wake_nonzero and in_iso |=> state_q == IPC_SLEEP)
    else $error("Nonzero wake did not send the isolating card to sleep.");
  chk_ptr_return: assert property (
    cfg_wr && cfg_index == IPC_OFS_WAKE && awake && cfg_wdata == card_number_q |=> res_ptr == 5'h00)
    else $error("Matching wake did not return the pointer.");
  chk_res_advance: assert property (
    s_cfg_read(IPC_OFS_RES_BYTE) and res_avail |=> res_ptr == $past(res_ptr) + 5'h01
      && cfg_rvalid && cfg_rdata == $past(res_byte))
    else $error("Resource read did not return the byte and advance.");
  chk_status_bit: assert property (
    s_cfg_read(IPC_OFS_RES_STATUS) |=> cfg_rdata == {7'h00, $past(res_avail)})
    else $error("Status read did not show availability.");
  chk_ldev_zero: assert property (
    s_cfg_read(IPC_OFS_LDEV_INDEX) |=> cfg_rdata == 8'h00)
    else $error("Logical device index read nonzero.");
  chk_range_gate: assert property (
    card_active |-> !range_check_active)
    else $error("Range check active while the card is active.");
  chk_channel_code: assert property (
    s_cfg_read(IPC_OFS_CHANNEL_0) or s_cfg_read(IPC_OFS_CHANNEL_1) |=> cfg_rdata == 8'h04)
    else $error("Channel register did not read the cascade code.");
  chk_ctrl_reset: assert property (
    wr_ctrl && cfg_wdata[0] && !cfg_wdata[2] |=> !card_active && io_base == 16'h0000
      && $stable(card_number_q))
    else $error("Control reset did not clear settings or touched the card number.");
  chk_read_port: assert property (
    cfg_wr && cfg_index == IPC_OFS_READ_PORT && (in_cfg || in_iso)
      |=> read_port_addr == {2'b00, $past(cfg_wdata), 2'b11})
    else $error("Read port address not built from written data.");
  chk_no_stray_move: assert property (
    cfg_rd && !in_cfg && !(cfg_wr && cfg_index == IPC_OFS_WAKE) |=> $stable(res_ptr))
    else $error("Pointer moved on a read outside configuration.");

endmodule : ipc_card_config

`default_nettype wire

// ==== src/ipc_pkg.sv ====
// Constants, register map and resource table for the card configuration block.
`default_nettype none

package ipc_pkg;

  // Card-level register indices.
  localparam logic [7:0] IPC_OFS_READ_PORT = 8'h00;
  localparam logic [7:0] IPC_OFS_ISOLATE = 8'h01;
  localparam logic [7:0] IPC_OFS_CFG_CTRL = 8'h02;
  localparam logic [7:0] IPC_OFS_WAKE = 8'h03;
  localparam logic [7:0] IPC_OFS_RES_BYTE = 8'h04;
  localparam logic [7:0] IPC_OFS_RES_STATUS = 8'h05;
  localparam logic [7:0] IPC_OFS_CARD_NUMBER = 8'h06;
  localparam logic [7:0] IPC_OFS_LDEV_INDEX = 8'h07;
  localparam logic [7:0] IPC_OFS_ACTIVATION = 8'h30;
  localparam logic [7:0] IPC_OFS_RANGE_CHECK = 8'h31;
  localparam logic [7:0] IPC_OFS_BASE_HIGH = 8'h60;
  localparam logic [7:0] IPC_OFS_BASE_LOW = 8'h61;
  localparam logic [7:0] IPC_OFS_IRQ_NUMBER = 8'h70;
  localparam logic [7:0] IPC_OFS_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IPC_OFS_CHANNEL_0 = 8'h74;
  localparam logic [7:0] IPC_OFS_CHANNEL_1 = 8'h75;

  // Field positions.
  localparam int IPC_BIT_CTRL_RESET = 0;
  localparam int IPC_BIT_CTRL_WAIT_KEY = 1;
  localparam int IPC_BIT_CTRL_CLR_CARD = 2;
  localparam int IPC_BIT_ACTIVE = 0;
  localparam int IPC_BIT_PATTERN = 0;
  localparam int IPC_BIT_RANGE_EN = 1;

  // Values after reset and fixed read values.
  localparam logic [7:0] IPC_RST_BYTE = 8'h00;
  localparam logic [7:0] IPC_CHANNEL_CASCADE = 8'h04;
  localparam logic [7:0] IPC_PATTERN_SET = 8'h55;
  localparam logic [7:0] IPC_PATTERN_CLR = 8'haa;
  localparam logic [1:0] IPC_PORT_HIGH_BITS = 2'h0;
  localparam logic [1:0] IPC_PORT_LOW_BITS = 2'h3;

  // Identifier bytes; values are arbitrary.
  localparam logic [31:0] IPC_VENDOR_ID = 32'h0000_0001;
  localparam logic [31:0] IPC_SERIAL_NO = 32'h0000_0002;
  localparam logic [7:0] IPC_ID_CHECKSUM = 8'h03;

  // Resource table length: serial identifier, checksum, resource list.
  localparam logic [4:0] IPC_RES_LEN = 5'h10;

  typedef enum logic [1:0] {
    IPC_WAIT_KEY = 2'b00,
    IPC_SLEEP = 2'b01,
    IPC_ISOLATE = 2'b11,
    IPC_CONFIG = 2'b10
  } ipc_state_type;

  // Constant resource table: identifier first, then the resource list.
  function automatic logic [7:0] ipc_res_rom(input logic [4:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      5'h00: b = IPC_VENDOR_ID[7:0];
      5'h01: b = IPC_VENDOR_ID[15:8];
      5'h02: b = IPC_VENDOR_ID[23:16];
      5'h03: b = IPC_VENDOR_ID[31:24];
      5'h04: b = IPC_SERIAL_NO[7:0];
      5'h05: b = IPC_SERIAL_NO[15:8];
      5'h06: b = IPC_SERIAL_NO[23:16];
      5'h07: b = IPC_SERIAL_NO[31:24];
      5'h08: b = IPC_ID_CHECKSUM;
      5'h09: b = 8'h47;
      5'h0a: b = 8'h01;
      5'h0b: b = 8'h00;
      5'h0c: b = 8'h01;
      5'h0d: b = 8'h08;
      5'h0e: b = 8'h79;
      5'h0f: b = 8'h00;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

endpackage : ipc_pkg

`default_nettype wire

// ==== src/ipc_res_reader.sv ====
// Resource pointer and byte fetch for identifier and resource data.
`default_nettype none

module ipc_res_reader (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pointer control
  input wire logic ptr_clear,
  input wire logic advance,
  // Pointer state and data
  output logic [4:0] ptr_q,
  output logic [7:0] res_byte_q,
  output logic res_avail
);
  import ipc_pkg::*;

  logic [4:0] ptr_d;

  // Next pointer: a clear wins, reading past the end holds the pointer.
  always_comb begin
    ptr_d = ptr_q;
    if (ptr_clear) begin
      ptr_d = 5'h00;
    end else if (advance && res_avail) begin
      ptr_d = ptr_q + 5'h01;
    end
  end

  // The byte at the pointer is fetched one edge ahead so reads see it at once.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= 5'h00;
      res_byte_q <= IPC_VENDOR_ID[7:0]; // First table byte, a plain constant.
    end else begin
      ptr_q <= ptr_d;
      res_byte_q <= ipc_res_rom(ptr_d);
    end
  end

  // A byte is available while the pointer lies inside the table.
  assign res_avail = (ptr_q < IPC_RES_LEN);

endmodule : ipc_res_reader

`default_nettype wire

// ==== sim/ipc_host_model.sv ====
// Host-side model that issues card-level register accesses.
`default_nettype none

module ipc_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port towards the card
  output logic [7:0] cfg_index,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle values at time zero.
  initial begin
    cfg_index = 8'h00;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 8'h00;
  end

  // One write strobe; idle lines are scrambled afterwards so stale data never looks valid.
  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge sys_clk);
    cfg_index <= idx;
    cfg_wdata <= dat;
    cfg_wr <= 1'b1;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_index <= ~idx;
    cfg_wdata <= ~dat;
    @(negedge sys_clk);
  endtask

  // One read strobe; the answer is judged by the bench monitor.
  task automatic bus_rd(input logic [7:0] idx);
    @(posedge sys_clk);
    cfg_index <= idx;
    cfg_rd <= 1'b1;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    cfg_index <= ~idx;
    @(negedge sys_clk);
  endtask
endmodule // ipc_host_model

`default_nettype wire

// ==== sim/tb_ipc_card_config.sv ====
// Self-checking bench for the card configuration block.
`default_nettype none

module tb_ipc_card_config;
  import ipc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk, arst_n, key_seen, iso_done, iso_lost;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata, range_pattern;
  logic cfg_wr, cfg_rd, cfg_rvalid, card_active, range_check_active;
  logic [15:0] io_base;
  logic [3:0] irq_number;
  logic [11:0] read_port_addr;
  ipc_state_type card_state;
  int err_total, n_checks, i;
  logic [7:0] exp_q[$];
  logic [31:0] rnd;
  localparam logic [55:0] RES_LIST = 56'h47_01_00_01_08_79_00;

  // Device under test.
  ipc_card_config i_ipc_card_config (.sys_clk(sys_clk), .arst_n(arst_n), .key_seen(key_seen),
    .iso_done(iso_done), .iso_lost(iso_lost), .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .card_active(card_active),
    .range_check_active(range_check_active), .range_pattern(range_pattern), .io_base(io_base),
    .irq_number(irq_number), .read_port_addr(read_port_addr), .card_state(card_state));

  // Host standing on the far side of the register port.
  ipc_host_model i_ipc_host_model (.sys_clk(sys_clk), .cfg_index(cfg_index), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata));

  // Free-running 100 MHz clock.
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected identifier and resource byte at a pointer position.
  function automatic logic [7:0] res_exp(input int p);
    logic [63:0] id;
    id = {IPC_SERIAL_NO, IPC_VENDOR_ID};
    if (p < 8) return id[8*p +: 8];
    if (p == 8) return IPC_ID_CHECKSUM;
    if (p < 16) return RES_LIST[8*(15-p) +: 8];
    return 8'h00;
  endfunction

  task automatic test_done();
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A read notes its expected byte before the strobe goes out.
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back(exp);
    i_ipc_host_model.bus_rd(idx);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    i_ipc_host_model.bus_wr(idx, dat);
  endtask

  task automatic st(input ipc_state_type s);
    chk({14'h0, card_state}, {14'h0, s});
  endtask

  // One-cycle protocol event: 0 key, 1 isolation done, 2 isolation lost.
  task automatic pulse(input int which);
    @(posedge sys_clk);
    key_seen <= (which == 0);
    iso_done <= (which == 1);
    iso_lost <= (which == 2);
    @(posedge sys_clk);
    {key_seen, iso_done, iso_lost} <= 3'h0;
    @(negedge sys_clk);
  endtask

  // Each read answer is compared with the oldest note.
  always @(negedge sys_clk) begin
    if (cfg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk({8'h00, cfg_rdata}, 16'hffff);
      else chk({8'h00, cfg_rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  // Hang guard.
  initial begin
    repeat (50000) @(posedge sys_clk);
    err_total++;
    test_done();
  end

  initial begin
    {arst_n, key_seen, iso_done, iso_lost} = 4'h0;
    err_total = 0;
    n_checks = 0;
    rnd = 32'habab5d7a;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    st(IPC_WAIT_KEY);
    chk({4'h0, read_port_addr}, 16'h0003); // Fixed address bits after reset.
    chk({8'h00, range_pattern}, 16'h00aa); // Cleared pattern gives 0xaa.
    chk({15'h0, card_active}, 16'h0000); // Reset leaves the card inactive.
    rd(IPC_OFS_CARD_NUMBER, 8'h00); // Card waiting for the key answers zero.
    pulse(0);
    st(IPC_SLEEP);
    wr(IPC_OFS_ACTIVATION, 8'h01); // Write in sleep is dropped.
    wr(IPC_OFS_WAKE, 8'h00);
    st(IPC_ISOLATE); // Zero wake isolates card number zero.
    pulse(2);
    st(IPC_SLEEP);
    wr(IPC_OFS_WAKE, 8'h00);
    wr(IPC_OFS_WAKE, 8'h07);
    st(IPC_SLEEP); // Nonzero wake sends the isolating card to sleep.
    wr(IPC_OFS_WAKE, 8'h00);
    wr(IPC_OFS_CARD_NUMBER, 8'h05);
    st(IPC_ISOLATE); // Card number refused before isolation ends.
    rd(IPC_OFS_CARD_NUMBER, 8'h00); // Not readable before isolation ends.
    pulse(1);
    // Host assigns the card number after isolation.
    wr(IPC_OFS_CARD_NUMBER, 8'h05);
    st(IPC_CONFIG); // Assigned card leaves isolation.
    rd(IPC_OFS_CARD_NUMBER, 8'h05); // Number reads back.
    rd(IPC_OFS_ACTIVATION, 8'h00); // Earlier write left no trace.
    rd(IPC_OFS_LDEV_INDEX, 8'h00); // Single device index.
    rd(IPC_OFS_CHANNEL_0, IPC_CHANNEL_CASCADE); // Cascade code.
    rd(IPC_OFS_CHANNEL_1, IPC_CHANNEL_CASCADE); // Cascade code.
    rd(8'h50, 8'h00); // Unmapped place reads zero.
    // Status before every byte, identifier first.
    for (i = 0; i <= 16; i++) begin
      rd(IPC_OFS_RES_STATUS, {7'h0, i < 16}); // Availability in bit 0 only.
      rd(IPC_OFS_RES_BYTE, res_exp(i)); // Byte then pointer advance.
    end
    wr(IPC_OFS_WAKE, 8'h00);
    st(IPC_SLEEP); // Configured card falls asleep.
    wr(IPC_OFS_WAKE, 8'h05);
    st(IPC_CONFIG); // Matching number wakes into configuration.
    rd(IPC_OFS_RES_STATUS, 8'h01); // Status read before the byte read.
    rd(IPC_OFS_RES_BYTE, res_exp(0)); // Pointer back at first byte.
    wr(IPC_OFS_RANGE_CHECK, 8'hff);
    rd(IPC_OFS_RANGE_CHECK, 8'h03); // Upper bits read zero.
    chk({8'h00, range_pattern}, 16'h0055); // Set pattern gives 0x55.
    chk({15'h0, range_check_active}, 16'h0001); // Acts while inactive.
    wr(IPC_OFS_ACTIVATION, 8'hff);
    rd(IPC_OFS_ACTIVATION, 8'h01); // Only bit 0 stored.
    chk({15'h0, card_active}, 16'h0001); // Card enabled.
    chk({15'h0, range_check_active}, 16'h0000); // Suppressed while active.
    rnd = lfsr(lfsr(rnd));
    wr(IPC_OFS_BASE_HIGH, rnd[15:8]);
    wr(IPC_OFS_BASE_LOW, rnd[7:0]);
    wr(IPC_OFS_IRQ_NUMBER, rnd[23:16]);
    wr(IPC_OFS_IRQ_TYPE, rnd[31:24]); // Type bits have no effect.
    chk(io_base, rnd[15:0]); // High and low base bytes.
    chk({12'h0, irq_number}, {12'h0, rnd[19:16]}); // Number in low nibble.
    rd(IPC_OFS_BASE_HIGH, rnd[15:8]); // High byte reads back.
    rd(IPC_OFS_BASE_LOW, rnd[7:0]); // Low byte reads back.
    wr(IPC_OFS_READ_PORT, 8'h20);
    chk({4'h0, read_port_addr}, 16'h0083); // Data forms address bits 2 to 9.
    wr(IPC_OFS_CFG_CTRL, 8'h01);
    chk({15'h0, card_active}, 16'h0000); // Settings reset.
    chk(io_base, 16'h0000); // Base cleared.
    rd(IPC_OFS_CARD_NUMBER, 8'h05); // Card number kept.
    wr(IPC_OFS_CFG_CTRL, 8'h04);
    rd(IPC_OFS_CARD_NUMBER, 8'h00); // Card number zeroed.
    wr(IPC_OFS_CFG_CTRL, 8'h02);
    st(IPC_WAIT_KEY); // Back to waiting for the key.
    repeat (4) @(posedge sys_clk);
    chk(16'(exp_q.size()), 16'h0000);
    test_done();
  end
endmodule // tb_ipc_card_config

`default_nettype wire
